// ==== src/sprd_buf_if.sv ====
// Read and load access to the buffered register copy
interface sprd_buf_if;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;

    modport user  (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
    modport store (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// ==== src/sprd_buffer.sv ====
module sprd_buffer (
    // Link clock and reset
    input  wire logic sclk,
    input  wire logic nrst,
    // Access port
    sprd_buf_if.store bus
);
    import sprd_pkg::*;

    logic [DATA_W-1:0] mem_reg  [MEM_DEPTH];
    logic [DATA_W-1:0] mem_next [MEM_DEPTH];

    // Load from the write path; addresses past the map are dropped
    always_comb begin
        mem_next = mem_reg;
        if (bus.wr_en && (bus.wr_addr <= ADDR_TOP)) begin
            mem_next[bus.wr_addr] = bus.wr_data;
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_reg[i] <= DATA_RST;
            end
        end else begin
            mem_reg <= mem_next;
        end
    end

    // Unimplemented addresses read as zero
    assign bus.rd_data = (bus.rd_addr <= ADDR_TOP) ? mem_reg[bus.rd_addr] : DATA_RST;

endmodule

// ==== src/sprd_pkg.sv ====
package sprd_pkg;

    // ------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------
    localparam int             INSTR_LEN      = 16;
    localparam logic [4:0]     INSTR_LAST_IDX = 5'h0F;
    localparam int             RW_POS         = 15;
    localparam int             CNT_HI         = 14;
    localparam int             CNT_LO         = 13;
    localparam int             ADDR_HI        = 12;
    localparam int             ADDR_ZERO_LO   = 7;
    localparam int             ADDR_USED_HI   = 6;
    localparam logic           RW_READ        = 1'b1;

    // ------------------------------------------------------------
    // Data and address widths
    // ------------------------------------------------------------
    localparam int             ADDR_W         = 13;
    localparam int             MEM_ADDR_W     = 7;
    localparam int             DATA_W         = 8;
    localparam int             MEM_DEPTH      = 91;
    localparam logic [6:0]     ADDR_TOP       = 7'h5A;
    localparam logic [2:0]     BIT_LAST_IDX   = 3'h7;
    localparam logic [12:0]    ADDR_STEP      = 13'h0001;
    localparam int             STAT_CNT_W     = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0]    INSTR_RST      = 16'h0000;
    localparam logic [12:0]    ADDR_RST       = 13'h0000;
    localparam logic [7:0]     DATA_RST       = 8'h00;
    localparam logic [4:0]     ICNT_RST       = 5'h00;
    localparam logic [2:0]     BITS_RST       = 3'h0;
    localparam logic [1:0]     LEFT_RST       = 2'h0;
    localparam logic [7:0]     STAT_CNT_RST   = 8'h00;

    // ------------------------------------------------------------
    // Frame sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INSTR,
        ST_READ,
        ST_IDLE
    } sprd_state_t;

endpackage

// ==== src/sprd_sync.sv ====
module sprd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset of the receiving domain
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Level from the far domain and its safe copy
    input  wire logic [WIDTH-1:0] d,
    output      logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // Two stages; the first one is seen by the second only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// ==== src/sprd_top.sv ====
// Overview of operation
// - Read shifts out one to four bytes.
// - Read bit valid at rising clock edge.
// - Read data on shared pin when selected.
// - Readback comes from buffered register copy.
// - Map spans 00h to 5Ah, seven bits.
// - Sixteen bit instructions only after power up.
// - Instruction holds direction, count, start address.
// - Count field codes one to four bytes.
// - Later byte addresses are generated internally.
// - Order bit switches to LSB first after two link clock edges.
// - MSB first: bits high first, address decrements.
// - LSB first: bits low first, address increments.
// - Instruction fills the first sixteen rising edges.
// - Capture on rising edge, launch on falling.
// - Chip select high releases both data pins.
module sprd_top (
    // System clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            nrst,
    // Serial link pins
    input  wire logic                            sclk,
    input  wire logic                            chip_select_n,
    input  wire logic                            sdio_in,
    output      logic                            sdio_out,
    output      logic                            sdio_oe,
    output      logic                            separate_output_pin,
    output      logic                            separate_output_oe,
    // Port configuration, system domain
    input  wire logic                            cfg_shared_pin,
    input  wire logic                            cfg_lsb_first,
    // Buffer load from the write path, link domain
    input  wire logic                            bufw_en,
    input  wire logic [sprd_pkg::MEM_ADDR_W-1:0] bufw_addr,
    input  wire logic [sprd_pkg::DATA_W-1:0]     bufw_data,
    // Status, system domain
    input  wire logic                            stat_clear,
    output      logic                            stat_read_busy,
    output      logic [sprd_pkg::STAT_CNT_W-1:0] stat_read_count,
    output      logic                            stat_addr_fault
);
    import sprd_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sprd_buf_if buf_bus ();

    logic [1:0]           cfg_sync;
    logic                 shared_mode;
    logic                 lsb_mode;

    sprd_state_t          state_reg;
    sprd_state_t          state_next;
    logic [4:0]           icnt_reg;
    logic [4:0]           icnt_next;
    logic [INSTR_LEN-1:0] instr_reg;
    logic [INSTR_LEN-1:0] instr_next;
    logic [INSTR_LEN-1:0] word;
    logic [2:0]           bits_reg;
    logic [2:0]           bits_next;
    logic [1:0]           left_reg;
    logic [1:0]           left_next;
    logic [ADDR_W-1:0]    addr_reg;
    logic [ADDR_W-1:0]    addr_next;
    logic                 busy_reg;
    logic                 busy_next;
    logic [7:0]           span_lo;
    logic [7:0]           span_hi;
    logic                 range_bad;

    logic                 rd_tog_reg;
    logic                 rd_tog_next;
    logic                 err_tog_reg;
    logic                 err_tog_next;

    logic                 tx_reg;
    logic                 tx_next;
    logic                 sdo_oe_reg;
    logic                 sdo_oe_next;
    logic                 sdio_oe_reg;
    logic                 sdio_oe_next;
    logic [2:0]           bit_idx;
    logic [DATA_W-1:0]    rd_byte;

    logic [2:0]           ev_sync;
    logic [1:0]           ev_prev_reg;
    logic [1:0]           ev_prev_next;
    logic                 busy_out_reg;
    logic                 busy_out_next;
    logic [STAT_CNT_W-1:0] count_reg;
    logic [STAT_CNT_W-1:0] count_next;
    logic                 fault_reg;
    logic                 fault_next;

    // ------------------------------------------------------------
    // Configuration into the link domain
    // ------------------------------------------------------------
    // The link clock only runs inside frames, so a new setting is
    // seen from the third rising edge of the next frame on. Software
    // should change order or pin mode between frames only.
    sprd_sync #(
        .WIDTH (2)
    ) u_cfg_sync (
        .clk   (sclk),
        .rst_n (nrst),
        .d     ({cfg_shared_pin, cfg_lsb_first}),
        .q     (cfg_sync)
    );

    assign shared_mode = cfg_sync[1];
    assign lsb_mode    = cfg_sync[0];

    // ------------------------------------------------------------
    // Buffered register copy
    // ------------------------------------------------------------
    sprd_buffer u_buffer (
        .sclk (sclk),
        .nrst (nrst),
        .bus  (buf_bus.store)
    );

    assign buf_bus.wr_en   = bufw_en;
    assign buf_bus.wr_addr = bufw_addr;
    assign buf_bus.wr_data = bufw_data;
    // Only the low seven address bits select a register
    assign buf_bus.rd_addr = addr_reg[ADDR_USED_HI:0];

    // Upper address bits set means nothing is implemented there
    assign rd_byte = (addr_reg[ADDR_HI:ADDR_ZERO_LO] == '0) ? buf_bus.rd_data : DATA_RST;

    // ------------------------------------------------------------
    // Instruction capture and address sequencing (rising edge)
    // ------------------------------------------------------------
    // Span of the whole transfer, used only for the fault flag; the
    // sequencer itself steps through gaps without skipping them.
    always_comb begin
        span_lo   = {1'b0, word[ADDR_USED_HI:0]};
        span_hi   = {1'b0, word[ADDR_USED_HI:0]};
        range_bad = 1'b0;
        if (lsb_mode) begin
            span_hi = span_lo + {6'h00, word[CNT_HI:CNT_LO]};
        end else begin
            range_bad = (span_lo < {6'h00, word[CNT_HI:CNT_LO]});
        end
        if (span_hi > {1'b0, ADDR_TOP}) begin
            range_bad = 1'b1;
        end
        if (word[ADDR_HI:ADDR_ZERO_LO] != '0) begin
            range_bad = 1'b1;
        end
    end

    // Next state of the frame sequencer
    always_comb begin
        state_next   = state_reg;
        icnt_next    = icnt_reg;
        instr_next   = instr_reg;
        bits_next    = bits_reg;
        left_next    = left_reg;
        addr_next    = addr_reg;
        rd_tog_next  = rd_tog_reg;
        err_tog_next = err_tog_reg;
        // Order decides which end the new bit enters from
        word = lsb_mode ? {sdio_in, instr_reg[INSTR_LEN-1:1]}
                        : {instr_reg[INSTR_LEN-2:0], sdio_in};
        unique case (state_reg)
            ST_INSTR: begin
                instr_next = word;
                icnt_next  = icnt_reg + 5'h01;
                // Only the sixteen bit form exists here
                if (icnt_reg == INSTR_LAST_IDX) begin
                    if (range_bad) begin
                        err_tog_next = ~err_tog_reg;
                    end
                    if (word[RW_POS] == RW_READ) begin
                        state_next  = ST_READ;
                        addr_next   = word[ADDR_HI:0];
                        left_next   = word[CNT_HI:CNT_LO];
                        bits_next   = BITS_RST;
                        rd_tog_next = ~rd_tog_reg;
                    end else begin
                        // Writes belong to the write path
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_READ: begin
                bits_next = bits_reg + 3'h1;
                if (bits_reg == BIT_LAST_IDX) begin
                    if (left_reg == LEFT_RST) begin
                        state_next = ST_IDLE;
                    end else begin
                        left_next = left_reg - 2'h1;
                        // Next byte address is made here
                        if (lsb_mode) begin
                            addr_next = addr_reg + ADDR_STEP;
                        end else begin
                            addr_next = addr_reg - ADDR_STEP;
                        end
                    end
                end
            end
            ST_IDLE: begin
                state_next = ST_IDLE;
            end
            // The fourth code of the state type is never entered; park
            // in ST_IDLE until chip select clears the frame, never guess a read
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Busy covers the data phase only, as seen from the next edge
        busy_next = (state_next == ST_READ);
    end

    // Frame state; chip select high clears it at once
    always_ff @(posedge sclk or negedge nrst or posedge chip_select_n) begin
        if (!nrst || chip_select_n) begin
            state_reg <= ST_INSTR;
            icnt_reg  <= ICNT_RST;
            instr_reg <= INSTR_RST;
            bits_reg  <= BITS_RST;
            left_reg  <= LEFT_RST;
            addr_reg  <= ADDR_RST;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            icnt_reg  <= icnt_next;
            instr_reg <= instr_next;
            bits_reg  <= bits_next;
            left_reg  <= left_next;
            addr_reg  <= addr_next;
            busy_reg  <= busy_next;
        end
    end

    // Event toggles survive chip select; a reset there would fake an event
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            rd_tog_reg  <= 1'b0;
            err_tog_reg <= 1'b0;
        end else begin
            rd_tog_reg  <= rd_tog_next;
            err_tog_reg <= err_tog_next;
        end
    end

    // ------------------------------------------------------------
    // Read data launch (falling edge)
    // ------------------------------------------------------------
    // Bit position within the current byte
    assign bit_idx = lsb_mode ? bits_reg : (BIT_LAST_IDX - bits_reg);

    // Launching on the falling edge gives a full half period of setup
    // before the controller samples on the next rising edge.
    always_comb begin
        tx_next      = tx_reg;
        sdo_oe_next  = 1'b0;
        sdio_oe_next = 1'b0;
        if (state_reg == ST_READ) begin
            tx_next = rd_byte[bit_idx];
            if (shared_mode) begin
                sdio_oe_next = 1'b1;
            end else begin
                sdo_oe_next = 1'b1;
            end
        end
    end

    // Pin drivers release as soon as chip select rises
    always_ff @(negedge sclk or negedge nrst or posedge chip_select_n) begin
        if (!nrst || chip_select_n) begin
            tx_reg      <= 1'b0;
            sdo_oe_reg  <= 1'b0;
            sdio_oe_reg <= 1'b0;
        end else begin
            tx_reg      <= tx_next;
            sdo_oe_reg  <= sdo_oe_next;
            sdio_oe_reg <= sdio_oe_next;
        end
    end

    // One data flop feeds both pins; only the enable differs
    assign sdio_out            = tx_reg;
    assign sdio_oe             = sdio_oe_reg;
    assign separate_output_pin = tx_reg;
    assign separate_output_oe  = sdo_oe_reg;

    // ------------------------------------------------------------
    // Status into the system domain
    // ------------------------------------------------------------
    sprd_sync #(
        .WIDTH (3)
    ) u_ev_sync (
        .clk   (sys_clk),
        .rst_n (nrst),
        .d     ({busy_reg, err_tog_reg, rd_tog_reg}),
        .q     (ev_sync)
    );

    // Count read instructions; fault is sticky and its set beats clear.
    // A busy level left high by a stopped link clock drops only when
    // chip select rises, which clears the source flop directly.
    always_comb begin
        ev_prev_next  = ev_sync[1:0];
        busy_out_next = ev_sync[2];
        count_next    = count_reg;
        fault_next    = fault_reg;
        if (ev_sync[0] != ev_prev_reg[0]) begin
            count_next = count_reg + 8'h01;
        end
        if (stat_clear) begin
            fault_next = 1'b0;
        end
        if (ev_sync[1] != ev_prev_reg[1]) begin
            fault_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ev_prev_reg  <= 2'h0;
            busy_out_reg <= 1'b0;
            count_reg    <= STAT_CNT_RST;
            fault_reg    <= 1'b0;
        end else begin
            ev_prev_reg  <= ev_prev_next;
            busy_out_reg <= busy_out_next;
            count_reg    <= count_next;
            fault_reg    <= fault_next;
        end
    end

    assign stat_read_busy  = busy_out_reg;
    assign stat_read_count = count_reg;
    assign stat_addr_fault = fault_reg;

endmodule

// ==== testbench/sprd_master.sv ====
module sprd_master (
    // Link pins driven by the controller
    output logic       sclk,
    output logic       chip_select_n,
    output logic       sdio_in,
    // Device answers
    input  wire logic  sdio_out,
    input  wire logic  sdio_oe,
    input  wire logic  separate_output_pin,
    input  wire logic  separate_output_oe,
    // Buffer load, link domain
    output logic       bufw_en,
    output logic [6:0] bufw_addr,
    output logic [7:0] bufw_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Serial controller model
    // ------------------------------------------------------------
    logic m_val;
    logic sep_w;

    // A released line toggles so a stale value can never pass as data
    assign sdio_in = sdio_oe ? sdio_out : m_val;
    assign sep_w = separate_output_oe ? separate_output_pin : ~m_val;

    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        m_val = 1'b0;
        bufw_en = 1'b0;
        bufw_addr = 7'h00;
        bufw_data = 8'h00;
    end

    // Deselected clocks, used only while reset is held
    task automatic spin(input int n);
        repeat (n) begin
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
        end
    endtask

    // One frame; read bits are taken at the rising edge after their launch.
    // One spare edge follows the last bit, so a late pin release shows up.
    task automatic frame(input logic [15:0] ins, input logic lsb, input logic shr, input logic ld,
                         input logic [6:0] la, input logic [7:0] ldd, output logic [31:0] rd);
        int n;
        n = ins[15] ? 8 * (int'(ins[14:13]) + 1) : 8;
        rd = 32'h0000_0000;
        #5 chip_select_n = 1'b0;
        for (int i = 0; i < 17 + n; i++) begin
            m_val = (i < 16) ? (lsb ? ins[i] : ins[15 - i]) : ~m_val;
            bufw_en = ld && (i == 2);
            bufw_addr = la;
            bufw_data = ldd;
            #6 sclk = 1'b1;
            if (i >= 16 && i < 16 + n) rd = {rd[30:0], shr ? sdio_in : sep_w};
            #6 sclk = 1'b0;
        end
        #6 chip_select_n = 1'b1;
    endtask
endmodule

// ==== testbench/sprd_top_asserts.sv ====
module sprd_top_asserts (
    // System clock and reset
    input wire logic                            sys_clk,
    input wire logic                            nrst,
    // Serial link pins
    input wire logic                            sclk,
    input wire logic                            chip_select_n,
    input wire logic                            sdio_in,
    input wire logic                            sdio_out,
    input wire logic                            sdio_oe,
    input wire logic                            separate_output_pin,
    input wire logic                            separate_output_oe,
    // Configuration
    input wire logic                            cfg_shared_pin,
    input wire logic                            cfg_lsb_first,
    // Buffer load
    input wire logic                            bufw_en,
    input wire logic [sprd_pkg::MEM_ADDR_W-1:0] bufw_addr,
    input wire logic [sprd_pkg::DATA_W-1:0]     bufw_data,
    // Status
    input wire logic                            stat_clear,
    input wire logic                            stat_read_busy,
    input wire logic [sprd_pkg::STAT_CNT_W-1:0] stat_read_count,
    input wire logic                            stat_addr_fault
);
    import sprd_pkg::*;

    // ------------------------------------------------------------
    // Frame tracking helpers
    // ------------------------------------------------------------
    logic [5:0]  edge_cnt;
    logic [15:0] instr_cap;
    logic [5:0]  drive_end;
    logic        oe_any;

    assign oe_any = sdio_oe | separate_output_oe;
    // One past the last rising edge that still sees read data
    assign drive_end = 6'h18 + {1'b0, instr_cap[14:13], 3'h0};

    // Count rising edges in the frame; saturate so an overlong frame cannot wrap
    always_ff @(posedge sclk or negedge nrst or posedge chip_select_n) begin
        if (!nrst) begin
            edge_cnt <= 6'h00;
            instr_cap <= 16'h0000;
        end else if (chip_select_n) begin
            edge_cnt <= 6'h00;
        end else begin
            if (edge_cnt != 6'h3F) edge_cnt <= edge_cnt + 6'h01;
            if (edge_cnt < 6'h10) instr_cap <= cfg_lsb_first ? {sdio_in, instr_cap[15:1]} : {instr_cap[14:0], sdio_in};
        end
    end

    sequence s_instr_phase;
        !chip_select_n && edge_cnt < 6'h10;
    endsequence
    sequence s_data_phase;
        !chip_select_n && edge_cnt >= 6'h10;
    endsequence
    sequence s_read_start;
        $rose(oe_any);
    endsequence

    a_idle_release: assert property (@(posedge sys_clk) disable iff (!nrst)
        chip_select_n |-> !oe_any) else $error("data pin driven while deselected");
    a_shared_choice: assert property (@(posedge sys_clk) disable iff (!nrst)
        sdio_oe |-> cfg_shared_pin && !separate_output_oe) else $error("shared pin driven in split mode");
    a_split_choice: assert property (@(posedge sys_clk) disable iff (!nrst)
        separate_output_oe |-> !cfg_shared_pin) else $error("separate pin driven in shared mode");
    a_instr_quiet: assert property (@(posedge sclk) disable iff (!nrst)
        s_instr_phase |-> !oe_any) else $error("pin driven during instruction");
    a_read_length: assert property (@(posedge sclk) disable iff (!nrst)
        s_data_phase |-> oe_any == (instr_cap[15] && edge_cnt < drive_end)) else $error("read drive window wrong");
    a_count_step: assert property (@(posedge sys_clk) disable iff (!nrst)
        $changed(stat_read_count) |-> stat_read_count == $past(stat_read_count) + 8'h01)
        else $error("read count jumped");
    a_fault_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(stat_addr_fault) |-> $past(stat_clear)) else $error("fault dropped without clear");
    a_busy_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_read_start |-> ##[1:6] stat_read_busy) else $error("busy missing for read");
endmodule

// ==== testbench/tb.sv ====
bind sprd_top sprd_top_asserts sprd_top_asserts_i (
    .sys_clk, .nrst, .sclk, .chip_select_n, .sdio_in, .sdio_out, .sdio_oe, .separate_output_pin,
    .separate_output_oe, .cfg_shared_pin, .cfg_lsb_first, .bufw_en, .bufw_addr, .bufw_data,
    .stat_clear, .stat_read_busy, .stat_read_count, .stat_addr_fault
);

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sprd_pkg::*;

    // ------------------------------------------------------------
    // Signals, instances and bench helpers
    // ------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cfg_shared_pin = 1'b0;
    logic        cfg_lsb_first = 1'b0;
    logic        stat_clear = 1'b0;
    logic        sclk, chip_select_n, sdio_in, sdio_out, sdio_oe, bufw_en;
    logic        separate_output_pin, separate_output_oe, stat_read_busy, stat_addr_fault;
    logic [6:0]  bufw_addr;
    logic [7:0]  bufw_data, stat_read_count;
    logic [7:0]  mem [0:90];
    logic [31:0] seed = 32'h0001_34F6;
    int          error_cnt = 0;
    int          check_count = 0;
    int          reads = 0;

    always #20 sys_clk = ~sys_clk;

    sprd_top sprd_top_i (
        .sys_clk, .nrst, .sclk, .chip_select_n, .sdio_in, .sdio_out, .sdio_oe, .separate_output_pin,
        .separate_output_oe, .cfg_shared_pin, .cfg_lsb_first, .bufw_en, .bufw_addr, .bufw_data,
        .stat_clear, .stat_read_busy, .stat_read_count, .stat_addr_fault
    );
    sprd_master sprd_master_i (
        .sclk, .chip_select_n, .sdio_in, .sdio_out, .sdio_oe, .separate_output_pin,
        .separate_output_oe, .bufw_en, .bufw_addr, .bufw_data
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Expected bit stream; places off the map or past the 13-bit wrap read zero
    function automatic logic [31:0] exp_rd(input logic [15:0] ins, input logic lsb);
        logic [12:0] a;
        logic [7:0]  v;
        logic [31:0] e;
        a = ins[12:0];
        e = 32'h0000_0000;
        for (int j = 0; j <= int'(ins[14:13]); j++) begin
            v = (a <= 13'h005A) ? mem[a[6:0]] : 8'h00;
            for (int b = 0; b < 8; b++) e = {e[30:0], lsb ? v[b] : v[7 - b]};
            a = lsb ? a + 13'h0001 : a - 13'h0001;
        end
        return e;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        logic [31:0] rd;
        logic [15:0] ins;
        logic [6:0]  a;
        int          k;
        for (k = 0; k < 91; k++) mem[k] = 8'h00;
        // The buffer clears on reset alone; give some link edges while reset is held
        fork
            sprd_master_i.spin(4);
        join_none
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        // Load both ends of the map, one place past it, and random places
        for (k = 0; k < 12; k++) begin
            seed = xs(seed);
            a = (k == 0) ? 7'h00 : (k == 1) ? 7'h5A : (k == 2) ? 7'h5B : 7'(seed[15:8] % 8'h5B);
            sprd_master_i.frame(16'h0000, 1'b0, 1'b0, 1'b1, a, seed[7:0], rd);
            if (a <= 7'h5A) mem[a] = seed[7:0];
        end
        // Every pin choice and bit order, every byte count, wrap corners first
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            cfg_shared_pin <= m[0];
            cfg_lsb_first <= m[1];
            @(posedge sys_clk);
            // An all-zero write lets the order setting settle before it matters
            sprd_master_i.frame(16'h0000, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00, rd);
            for (k = 0; k < 12; k++) begin
                seed = xs(seed);
                ins = {1'b1, 2'(k % 4), 6'h00, 7'(seed[15:8] % 8'h5B)};
                if (k < 4) ins[6:0] = m[1] ? 7'h5A : 7'h01;
                sprd_master_i.frame(ins, m[1], m[0], 1'b0, 7'h00, 8'h00, rd);
                reads++;
                chk(rd, exp_rd(ins, m[1]));
            end
        end
        // Clear the fault left by the wrap reads, then provoke a new one
        @(posedge sys_clk);
        stat_clear <= 1'b1;
        @(posedge sys_clk);
        stat_clear <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, stat_addr_fault}, 32'h0);
        sprd_master_i.frame(16'h8F85, 1'b1, 1'b1, 1'b0, 7'h00, 8'h00, rd);
        reads++;
        chk(rd, 32'h0000_0000);
        for (k = 0; k < 20 && stat_addr_fault !== 1'b1; k++) @(posedge sys_clk);
        chk({31'h0, stat_addr_fault}, 32'h1);
        for (k = 0; k < 20 && stat_read_count !== 8'(reads); k++) @(posedge sys_clk);
        chk({24'h0, stat_read_count}, 32'(reads));
        // Busy crosses late, so give it time to fall after the last frame
        repeat (4) @(posedge sys_clk);
        chk({31'h0, stat_read_busy}, 32'h0);
        close_out();
    end
endmodule
